// ==== common/acc_pkg.sv ====
package acc_pkg;

    // ==========================================================
    // Register indices (printed offsets are word indices)
    // ==========================================================
    localparam logic [7:0] IDX_CHAN1_OFFSET_CAL_LOW  = 8'h10;
    localparam logic [7:0] IDX_CHAN1_GAIN_CAL_HIGH   = 8'h11;
    localparam logic [7:0] IDX_CHAN1_GAIN_CAL_LOW    = 8'h12;
    localparam logic [7:0] IDX_CHAN2_CONFIG          = 8'h13;
    localparam logic [7:0] IDX_CHAN2_OFFSET_CAL_HIGH = 8'h14;
    localparam logic [7:0] IDX_CHAN2_OFFSET_CAL_LOW  = 8'h15;
    localparam logic [7:0] IDX_CHAN2_GAIN_CAL_HIGH   = 8'h16;
    localparam logic [7:0] IDX_CHAN2_GAIN_CAL_LOW    = 8'h17;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int PHASE_MSB      = 15;
    localparam int PHASE_LSB      = 6;
    localparam int DC_BYPASS_BIT  = 2;
    localparam int INSEL_MSB      = 1;
    localparam int INSEL_LSB      = 0;
    localparam int LOW_BYTE_MSB   = 15;
    localparam int LOW_BYTE_LSB   = 8;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [15:0] RST_GAIN_HIGH   = 16'h8000;
    localparam logic [15:0] RST_OFFSET_HIGH = 16'h0000;
    localparam logic [7:0]  RST_LOW_BYTE    = 8'h00;
    localparam logic [9:0]  RST_PHASE       = 10'h000;
    localparam logic        RST_DC_BYPASS   = 1'b0;

    // ==========================================================
    // Input selector encodings
    // ==========================================================
    typedef enum logic [1:0] {
        ACC_IN_NORMAL  = 2'h0,
        ACC_IN_SHORTED = 2'h1,
        ACC_IN_TEST_P  = 2'h2,
        ACC_IN_TEST_N  = 2'h3
    } acc_insel_t;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [9:0] phase_delay;
        logic       dc_filter_bypass;
        acc_insel_t input_select;
    } acc_chan_cfg_t;

    typedef struct packed {
        logic [23:0] offset;
        logic [23:0] gain;
    } acc_cal_t;

endpackage

// ==== logic/acc_regs.sv ====
// Behaviour
// - Config bits 15:6 hold signed phase delay
// - Config bit 2 bypasses DC filter
// - Two-bit input select: normal, short, test
// - Config resets to normal, zero phase, global
// - Chan1 offset low byte in upper byte
// - Chan1 gain high word resets 8000h
// - Chan1 gain low byte upper, lower zero
// - Chan2 offset high word RW, reset zero
// - Chan2 offset low byte upper, lower zero
// - Chan2 gain high word resets 8000h
module acc_regs
    import acc_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    output acc_chan_cfg_t      chan2_cfg,
    output logic [23:0]        chan1_gain,
    output logic [7:0]         chan1_offset_low_byte,
    output acc_cal_t           chan2_cal,
    output logic               chan2_phase_negative
);

    // ==========================================================
    // Storage
    // ==========================================================
    logic [7:0]  chan1_offset_low;
    logic [15:0] chan1_gain_high;
    logic [7:0]  chan1_gain_low;
    logic [9:0]  chan2_phase;
    logic        chan2_bypass;
    logic [1:0]  chan2_insel;
    logic [15:0] chan2_offset_high;
    logic [7:0]  chan2_offset_low;
    logic [15:0] chan2_gain_high;
    logic [7:0]  chan2_gain_low;

    logic [7:0]  next_chan1_offset_low;
    logic [15:0] next_chan1_gain_high;
    logic [7:0]  next_chan1_gain_low;
    logic [9:0]  next_chan2_phase;
    logic        next_chan2_bypass;
    logic [1:0]  next_chan2_insel;
    logic [15:0] next_chan2_offset_high;
    logic [7:0]  next_chan2_offset_low;
    logic [15:0] next_chan2_gain_high;
    logic [7:0]  next_chan2_gain_low;

    logic        wr_en;
    logic        rd_en;
    logic [7:0]  idx;
    logic        idx_ok;
    logic [15:0] wmask;
    logic [15:0] wd;

    // ==========================================================
    // Bus decode
    // ==========================================================
    // One wait state: pready answers in the second access cycle
    assign idx    = paddr[9:2];
    assign idx_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
                    && (idx >= IDX_CHAN1_OFFSET_CAL_LOW)
                    && (idx <= IDX_CHAN2_GAIN_CAL_LOW);
    // Commit only at the pready edge, so a held request lands once
    assign wr_en  = psel && penable && pwrite && idx_ok && pready;
    assign rd_en  = psel && penable && !pwrite;
    assign wmask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Merge write data into the current value under byte strobes
    function automatic logic [15:0] merge(input logic [15:0] cur,
                                          input logic [15:0] dat,
                                          input logic [15:0] msk);
        merge = (cur & ~msk) | (dat & msk);
    endfunction

    // ==========================================================
    // Register next values
    // ==========================================================
    always_comb begin
        logic [15:0] cfg_cur;
        logic [15:0] cfg_new;
        cfg_cur = '0;
        cfg_new = '0;
        wd      = pwdata[15:0];
        next_chan1_offset_low  = chan1_offset_low;
        next_chan1_gain_high   = chan1_gain_high;
        next_chan1_gain_low    = chan1_gain_low;
        next_chan2_phase       = chan2_phase;
        next_chan2_bypass      = chan2_bypass;
        next_chan2_insel       = chan2_insel;
        next_chan2_offset_high = chan2_offset_high;
        next_chan2_offset_low  = chan2_offset_low;
        next_chan2_gain_high   = chan2_gain_high;
        next_chan2_gain_low    = chan2_gain_low;
        if (wr_en) begin
            case (idx)
                IDX_CHAN1_OFFSET_CAL_LOW: begin
                    if (pstrb[1]) begin
                        next_chan1_offset_low = wd[LOW_BYTE_MSB:LOW_BYTE_LSB];
                    end
                end
                IDX_CHAN1_GAIN_CAL_HIGH: begin
                    next_chan1_gain_high = merge(chan1_gain_high, wd, wmask);
                end
                IDX_CHAN1_GAIN_CAL_LOW: begin
                    if (pstrb[1]) begin
                        next_chan1_gain_low = wd[LOW_BYTE_MSB:LOW_BYTE_LSB];
                    end
                end
                IDX_CHAN2_CONFIG: begin
                    cfg_cur = {chan2_phase, 3'h0, chan2_bypass, chan2_insel};
                    cfg_new = merge(cfg_cur, wd, wmask);
                    next_chan2_phase  = cfg_new[PHASE_MSB:PHASE_LSB];
                    next_chan2_bypass = cfg_new[DC_BYPASS_BIT];
                    next_chan2_insel  = cfg_new[INSEL_MSB:INSEL_LSB];
                    // Bits 5:3 are dropped here so they never store
                end
                IDX_CHAN2_OFFSET_CAL_HIGH: begin
                    next_chan2_offset_high =
                        merge(chan2_offset_high, wd, wmask);
                end
                IDX_CHAN2_OFFSET_CAL_LOW: begin
                    if (pstrb[1]) begin
                        next_chan2_offset_low = wd[LOW_BYTE_MSB:LOW_BYTE_LSB];
                    end
                end
                IDX_CHAN2_GAIN_CAL_HIGH: begin
                    next_chan2_gain_high = merge(chan2_gain_high, wd, wmask);
                end
                IDX_CHAN2_GAIN_CAL_LOW: begin
                    if (pstrb[1]) begin
                        next_chan2_gain_low = wd[LOW_BYTE_MSB:LOW_BYTE_LSB];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan1_offset_low  <= RST_LOW_BYTE;
            chan1_gain_high   <= RST_GAIN_HIGH;
            chan1_gain_low    <= RST_LOW_BYTE;
            chan2_phase       <= RST_PHASE;
            chan2_bypass      <= RST_DC_BYPASS;
            chan2_insel       <= ACC_IN_NORMAL;
            chan2_offset_high <= RST_OFFSET_HIGH;
            chan2_offset_low  <= RST_LOW_BYTE;
            chan2_gain_high   <= RST_GAIN_HIGH;
            chan2_gain_low    <= RST_LOW_BYTE;
        end else begin
            chan1_offset_low  <= next_chan1_offset_low;
            chan1_gain_high   <= next_chan1_gain_high;
            chan1_gain_low    <= next_chan1_gain_low;
            chan2_phase       <= next_chan2_phase;
            chan2_bypass      <= next_chan2_bypass;
            chan2_insel       <= next_chan2_insel;
            chan2_offset_high <= next_chan2_offset_high;
            chan2_offset_low  <= next_chan2_offset_low;
            chan2_gain_high   <= next_chan2_gain_high;
            chan2_gain_low    <= next_chan2_gain_low;
        end
    end

    // ==========================================================
    // Read path and bus answer
    // ==========================================================
    logic [31:0] next_prdata;
    logic        next_pslverr;

    always_comb begin
        next_prdata  = '0;
        next_pslverr = 1'b0;
        if (rd_en) begin
            case (idx_ok ? idx : 8'hff)
                IDX_CHAN1_OFFSET_CAL_LOW:
                    next_prdata = {16'h0, chan1_offset_low, 8'h00};
                IDX_CHAN1_GAIN_CAL_HIGH:
                    next_prdata = {16'h0, chan1_gain_high};
                IDX_CHAN1_GAIN_CAL_LOW:
                    next_prdata = {16'h0, chan1_gain_low, 8'h00};
                IDX_CHAN2_CONFIG:
                    next_prdata = {16'h0, chan2_phase, 3'h0,
                                   chan2_bypass, chan2_insel};
                IDX_CHAN2_OFFSET_CAL_HIGH:
                    next_prdata = {16'h0, chan2_offset_high};
                IDX_CHAN2_OFFSET_CAL_LOW:
                    next_prdata = {16'h0, chan2_offset_low, 8'h00};
                IDX_CHAN2_GAIN_CAL_HIGH:
                    next_prdata = {16'h0, chan2_gain_high};
                IDX_CHAN2_GAIN_CAL_LOW:
                    next_prdata = {16'h0, chan2_gain_low, 8'h00};
                default:
                    next_pslverr = 1'b1;
            endcase
        end else if (psel && penable && !idx_ok) begin
            next_pslverr = 1'b1;
        end
    end

    // pready is registered, so each access phase lasts two cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ==========================================================
    // Outputs to the datapath
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan2_cfg             <= '0;
            chan1_gain            <= {RST_GAIN_HIGH, RST_LOW_BYTE};
            chan1_offset_low_byte <= RST_LOW_BYTE;
            chan2_cal             <= {RST_OFFSET_HIGH, RST_LOW_BYTE,
                                      RST_GAIN_HIGH, RST_LOW_BYTE};
            chan2_phase_negative  <= 1'b0;
        end else begin
            chan2_cfg             <= {next_chan2_phase, next_chan2_bypass,
                                      acc_insel_t'(next_chan2_insel)};
            chan1_gain            <= {next_chan1_gain_high,
                                      next_chan1_gain_low};
            chan1_offset_low_byte <= next_chan1_offset_low;
            chan2_cal             <= {next_chan2_offset_high,
                                      next_chan2_offset_low,
                                      next_chan2_gain_high,
                                      next_chan2_gain_low};
            chan2_phase_negative  <= next_chan2_phase[9];
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    AST_CFG_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && $past(rd_en) && $past(idx) == IDX_CHAN2_CONFIG
         && $past(idx_ok)) |-> prdata[5:3] == 3'h0)
        else $error("config reserved bits read nonzero");
    AST_LOW_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && $past(rd_en) && $past(idx_ok)
         && $past(idx) != IDX_CHAN1_GAIN_CAL_HIGH
         && $past(idx) != IDX_CHAN2_CONFIG
         && $past(idx) != IDX_CHAN2_OFFSET_CAL_HIGH
         && $past(idx) != IDX_CHAN2_GAIN_CAL_HIGH)
        |-> prdata[7:0] == 8'h00)
        else $error("low register reserved byte read nonzero");
    AST_PHASE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_CHAN2_CONFIG && pstrb[1] && pstrb[0])
        |=> chan2_cfg.phase_delay == $past(pwdata[15:6]))
        else $error("phase delay not stored");
    AST_BYPASS_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_CHAN2_CONFIG && pstrb[0])
        |=> chan2_cfg.dc_filter_bypass == $past(pwdata[2]))
        else $error("dc bypass not stored");
    AST_INSEL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_CHAN2_CONFIG && pstrb[0])
        |=> chan2_cfg.input_select == $past(pwdata[1:0]))
        else $error("input select not stored");
    AST_CFG_RESET: assert property (@(posedge pclk)
        $rose(presetn) |-> chan2_cfg == '0)
        else $error("config not reset");
    AST_C1GAIN_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_CHAN1_GAIN_CAL_LOW && pstrb[1])
        |=> chan1_gain[7:0] == $past(pwdata[15:8]))
        else $error("chan1 gain low byte wrong");
    AST_C1GAIN_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_CHAN1_GAIN_CAL_HIGH && pstrb[1:0] == 2'h3)
        |=> chan1_gain[23:8] == $past(pwdata[15:0]))
        else $error("chan1 gain high word wrong");
    AST_C2OFF_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_CHAN2_OFFSET_CAL_HIGH && pstrb[1:0] == 2'h3)
        |=> chan2_cal.offset[23:8] == $past(pwdata[15:0]))
        else $error("chan2 offset high wrong");
    AST_C2OFF_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_CHAN2_OFFSET_CAL_LOW && pstrb[1])
        |=> chan2_cal.offset[7:0] == $past(pwdata[15:8]))
        else $error("chan2 offset low wrong");
    AST_C2GAIN_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_CHAN2_GAIN_CAL_HIGH && pstrb[1:0] == 2'h3)
        |=> chan2_cal.gain[23:8] == $past(pwdata[15:0]))
        else $error("chan2 gain high wrong");
    AST_C1OFF_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_CHAN1_OFFSET_CAL_LOW && !pstrb[1])
        |=> $stable(chan1_offset_low_byte))
        else $error("low-lane write changed offset byte");

endmodule

// ==== testbench/acc_host.sv ====
module acc_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'h0;
    end

    // ==========================================================
    // One transfer, held until pready is seen at an edge
    // ==========================================================
    task automatic xfer(input logic wr, input logic [11:0] addr,
                        input logic [15:0] wd, input logic [3:0] strb,
                        output logic [31:0] rd, output logic err,
                        output logic to);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= {16'h0000, wd};
        pstrb  <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        to  = (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Address and write data toggle on release so stale values cannot pass as valid
        paddr   <= ~addr;
        pwdata  <= ~{16'h0000, wd};
    endtask
endmodule

// ==== testbench/acc_regs_tb.sv ====
module acc_regs_tb
    import acc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic [3:0]    pstrb;
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    acc_chan_cfg_t chan2_cfg;
    logic [23:0]   chan1_gain;
    logic [7:0]    chan1_offset_low_byte;
    acc_cal_t      chan2_cal;
    logic          chan2_phase_negative;
    logic [31:0]   rd;
    logic          err;
    int            n_errors;
    int            total_checks;

    localparam logic [15:0] RST_V [8] = '{16'h0000, 16'h8000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
    localparam logic [15:0] MASK [8] = '{16'hff00, 16'hffff, 16'hff00,
        16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00};

    acc_regs acc_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .chan2_cfg(chan2_cfg), .chan1_gain(chan1_gain),
        .chan1_offset_low_byte(chan1_offset_low_byte),
        .chan2_cal(chan2_cal), .chan2_phase_negative(chan2_phase_negative));

    acc_host acc_host_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] addr,
                       input logic [15:0] wd, input logic [3:0] strb);
        logic to;
        acc_host_i.xfer(wr, addr, wd, strb, rd, err, to);
        // Outputs are looked at once the commit edge has settled
        @(negedge pclk);
        if (to === 1'b1) begin
            n_errors++;
            finish_test();
        end
    endtask

    function automatic logic [11:0] adr(input int i);
        return {2'b00, 8'h10 + i[7:0], 2'b00};
    endfunction

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic reset_values();
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, adr(i), 16'h0000, 4'hf);
            check("reset read", rd, {16'h0000, RST_V[i]});
            check("reset err", {31'h0, err}, 32'h0);
        end
        check("reset cfg", {19'h0, chan2_cfg}, 32'h0);
        check("reset gain1", {8'h00, chan1_gain}, 32'h0080_0000);
        check("reset off2", {8'h00, chan2_cal.offset}, 32'h0);
        check("reset gain2", {8'h00, chan2_cal.gain}, 32'h0080_0000);
    endtask

    task automatic write_all();
        logic [15:0] d [8];
        for (int i = 0; i < 8; i++) begin
            d[i] = 16'h5aff + 16'h1111 * i[15:0];
            bus(1'b1, adr(i), d[i], 4'hf);
        end
        // Reads only after all writes, so a wrong decode shows as overlap
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, adr(i), 16'h0000, 4'hf);
            check("readback", rd, {16'h0000, d[i] & MASK[i]});
        end
        check("off1 byte", {24'h0, chan1_offset_low_byte},
              {24'h0, d[0][15:8]});
        check("gain1", {8'h00, chan1_gain}, {8'h00, d[1], d[2][15:8]});
        check("cfg", {19'h0, chan2_cfg},
              {19'h0, d[3][15:6], d[3][2], d[3][1:0]});
        check("off2", {8'h00, chan2_cal.offset},
              {8'h00, d[4], d[5][15:8]});
        check("gain2", {8'h00, chan2_cal.gain},
              {8'h00, d[6], d[7][15:8]});
    endtask

    task automatic cfg_fields();
        logic [9:0] ph [4];
        logic [1:0] s;
        ph = '{10'h200, 10'h1ff, 10'h001, 10'h3ff};
        for (int i = 0; i < 4; i++) begin
            s = i[1:0];
            bus(1'b1, adr(3), {ph[i], 3'b111, s[0], s}, 4'hf);
            check("insel", {30'h0, chan2_cfg.input_select}, {30'h0, s});
            check("phase", {22'h0, chan2_cfg.phase_delay}, {22'h0, ph[i]});
            check("sign", {31'h0, chan2_phase_negative}, {31'h0, ph[i][9]});
            check("bypass", {31'h0, chan2_cfg.dc_filter_bypass},
                  {31'h0, s[0]});
            bus(1'b0, adr(3), 16'h0000, 4'hf);
            check("cfg read", rd, {16'h0, ph[i], 3'b000, s[0], s});
        end
    endtask

    task automatic refusals();
        bus(1'b1, adr(8), 16'hffff, 4'hf);
        check("unmapped err", {31'h0, err}, 32'h1);
        bus(1'b1, 12'h04d, 16'h0000, 4'hf);
        check("misaligned err", {31'h0, err}, 32'h1);
        check("cfg kept", {22'h0, chan2_cfg.phase_delay}, {22'h0, 10'h3ff});
        bus(1'b1, adr(5), 16'h0000, 4'h1);
        bus(1'b0, adr(5), 16'h0000, 4'hf);
        check("strobe kept", rd, 32'h0000_b000);
        bus(1'b1, adr(0), 16'h0000, 4'h1);
        check("strobe off1", {24'h0, chan1_offset_low_byte}, 32'h0000_005a);
        bus(1'b0, adr(-1), 16'h0000, 4'hf);
        check("read err", {31'h0, err}, 32'h1);
    endtask

    task automatic mid_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("rst cfg", {19'h0, chan2_cfg}, 32'h0);
        check("rst gain1", {8'h00, chan1_gain}, 32'h0080_0000);
        check("rst off1", {24'h0, chan1_offset_low_byte}, 32'h0);
        bus(1'b0, adr(6), 16'h0000, 4'hf);
        check("rst gain2 read", rd, 32'h0000_8000);
    endtask

    initial begin
        n_errors = 0;
        total_checks = 0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        write_all();
        cfg_fields();
        refusals();
        mid_reset();
        finish_test();
    end
endmodule
